// File: core/iwc_defs.svh
// iwc_defs.svh: register offsets, field positions and reset values of the
// interrupt wake and context save block. definitions only.
`ifndef IWC_DEFS_SVH
`define IWC_DEFS_SVH

`define IWC_ADDR_W        12
`define IWC_BANK_W        5
`define IWC_LOC_W         7
`define IWC_SHADOW_BANK   5'h1F
// register locations inside any bank (low 7 address bits)
`define IWC_LOC_CTRL      7'h0B
`define IWC_LOC_EDGE      7'h0C
`define IWC_LOC_PRF3      7'h0D
`define IWC_LOC_MASK      7'h0E
`define IWC_LOC_STAT      7'h0F
// shadow locations, bank 31 only
`define IWC_LOC_SH_STATUS 7'h64
`define IWC_LOC_SH_W      7'h65
`define IWC_LOC_SH_BANK   7'h66
`define IWC_LOC_SH_PCLH   7'h67
`define IWC_LOC_SH_P0L    7'h68
`define IWC_LOC_SH_P0H    7'h69
`define IWC_LOC_SH_P1L    7'h6A
`define IWC_LOC_SH_P1H    7'h6B
// bits of the control, edge select and flag 3 registers
`define IWC_BIT_MIE       7
`define IWC_BIT_EXTEN     4
`define IWC_BIT_EXTFLG    1
`define IWC_BIT_EDGE      0
`define IWC_BIT_CAP3      4
// status bits of the interrupt status register
`define IWC_ST_EXT        0
`define IWC_ST_CAP3       1
`define IWC_ST_WAKE       2
// expiry and power-down bits of the core status register, kept out of the copy
`define IWC_STATUS_KEEP   8'h18
`define IWC_RST_BYTE      8'h00
`define IWC_RST_EDGE      8'h01

`endif

// File: core/iwc_pkg.sv
// iwc_pkg: types of the interrupt wake and context save block.
// assumes iwc_defs.svh carries the register offsets, field positions and reset values.
package iwc_pkg;
  typedef enum logic [1:0] {
    IWC_RUN   = 2'b00,
    IWC_HALT  = 2'b01,
    IWC_STEP  = 2'b11,
    IWC_ENTER = 2'b10
  } iwc_state_e;
endpackage

// File: core/iwc_core.sv
// iwc_core: wake from halt, external pin edge interrupt, context shadowing.
// assumes the core samples outputs as pulses/levels and keeps its live
// registers itself, loading them from restore_*_o when restore_o pulses.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "iwc_defs.svh"

module iwc_core (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        ext_pin_i,
  input  wire logic        capture3_event_i,
  input  wire logic        cap3_clockless_i,
  input  wire logic        halt_i,
  input  wire logic        instr_done_i,
  input  wire logic        retfie_i,
  input  wire logic [12:0] pc_i,
  input  wire logic [7:0]  live_w_i,
  input  wire logic [7:0]  live_status_i,
  input  wire logic [7:0]  live_bsr_i,
  input  wire logic [7:0]  live_pclh_i,
  input  wire logic [7:0]  live_p0l_i,
  input  wire logic [7:0]  live_p0h_i,
  input  wire logic [7:0]  live_p1l_i,
  input  wire logic [7:0]  live_p1h_i,
  output logic             clk_run_o,
  output logic             vector_o,
  output logic             push_o,
  output logic      [12:0] push_pc_o,
  output logic             restore_o,
  output logic      [7:0]  restore_w_o,
  output logic      [7:0]  restore_status_o,
  output logic      [7:0]  restore_bsr_o,
  output logic      [7:0]  restore_pclh_o,
  output logic      [7:0]  restore_p0l_o,
  output logic      [7:0]  restore_p0h_o,
  output logic      [7:0]  restore_p1l_o,
  output logic      [7:0]  restore_p1h_o,
  output logic             irq_o
);

  // shadow order: status, w, bsr, pclh, p0l, p0h, p1l, p1h
  logic [7:0] shadow_r [8];
  logic [7:0] shadow_nxt [8];
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] edge_r, edge_nxt;
  logic [7:0] prf3_r, prf3_nxt;
  logic [7:0] mask_r, mask_nxt;
  logic [7:0] stat_r, stat_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       pin_d_r, pin_d_nxt;
  logic       vec_r, vec_nxt;
  logic       push_r, push_nxt;
  logic       rest_r, rest_nxt;
  logic       irq_r, irq_nxt;
  logic       clk_run_r, clk_run_nxt;
  logic [12:0] push_pc_r, push_pc_nxt;
  iwc_pkg::iwc_state_e state_r, state_nxt;

  logic [`IWC_BANK_W-1:0] bank;
  logic [`IWC_LOC_W-1:0]  loc;
  logic ext_edge;
  logic mie;
  logic pending;
  logic wake_src;

  function automatic logic hit(input logic strobe, input logic [6:0] where);
    hit = strobe && (loc == where);
  endfunction

  function automatic logic sh_hit(input logic strobe, input logic [2:0] idx);
    sh_hit = strobe && (bank == `IWC_SHADOW_BANK)
             && (loc == (`IWC_LOC_SH_STATUS + {4'h0, idx}));
  endfunction

  always_comb begin
    bank = addr_i[`IWC_ADDR_W-1:`IWC_LOC_W];
    loc  = addr_i[`IWC_LOC_W-1:0];
    mie  = ctrl_r[`IWC_BIT_MIE];
    // pin sampled synchronously; rising when edge select is one
    ext_edge = edge_r[`IWC_BIT_EDGE] ? (ext_pin_i && !pin_d_r)
                                     : (!ext_pin_i && pin_d_r);
    pending = (ctrl_r[`IWC_BIT_EXTFLG] && ctrl_r[`IWC_BIT_EXTEN])
           || (prf3_r[`IWC_BIT_CAP3] && mask_r[`IWC_ST_CAP3]);
    // waking sources must keep running with the system clock stopped
    wake_src = (ctrl_r[`IWC_BIT_EXTFLG] && ctrl_r[`IWC_BIT_EXTEN])
            || (prf3_r[`IWC_BIT_CAP3] && cap3_clockless_i);
  end

  always_comb begin
    ctrl_nxt  = ctrl_r;
    edge_nxt  = edge_r;
    prf3_nxt  = prf3_r;
    mask_nxt  = mask_r;
    stat_nxt  = stat_r;
    pin_d_nxt = ext_pin_i;
    for (int i = 0; i < 8; i++) begin
      shadow_nxt[i] = shadow_r[i];
      if (sh_hit(wr_i, 3'(i))) begin
        shadow_nxt[i] = wdata_i;
      end
    end
    if (hit(wr_i, `IWC_LOC_CTRL)) begin
      ctrl_nxt = wdata_i;
    end
    if (hit(wr_i, `IWC_LOC_EDGE)) begin
      edge_nxt = {7'h00, wdata_i[`IWC_BIT_EDGE]};
    end
    if (hit(wr_i, `IWC_LOC_PRF3)) begin
      prf3_nxt = wdata_i & 8'h10;
    end
    if (hit(wr_i, `IWC_LOC_MASK)) begin
      mask_nxt = wdata_i & 8'h07;
    end
    if (hit(wr_i, `IWC_LOC_STAT)) begin
      stat_nxt = stat_r & ~wdata_i;
    end
    // hardware set wins over a software clear in the same cycle
    if (ext_edge) begin
      ctrl_nxt[`IWC_BIT_EXTFLG] = 1'b1;
      stat_nxt[`IWC_ST_EXT] = 1'b1;
    end
    if (capture3_event_i) begin
      prf3_nxt[`IWC_BIT_CAP3] = 1'b1;
      stat_nxt[`IWC_ST_CAP3] = 1'b1;
    end
    state_nxt   = state_r;
    vec_nxt     = 1'b0;
    push_nxt    = 1'b0;
    rest_nxt    = 1'b0;
    push_pc_nxt = push_pc_r;
    clk_run_nxt = 1'b1;
    unique case (state_r)
      iwc_pkg::IWC_RUN: begin
        if (halt_i) begin
          state_nxt   = iwc_pkg::IWC_HALT;
          clk_run_nxt = 1'b0;
        end else if (mie && pending) begin
          state_nxt = iwc_pkg::IWC_ENTER;
        end
      end
      iwc_pkg::IWC_HALT: begin
        clk_run_nxt = 1'b0;
        if (wake_src) begin
          state_nxt   = iwc_pkg::IWC_STEP;
          clk_run_nxt = 1'b1;
          stat_nxt[`IWC_ST_WAKE] = 1'b1;
        end
      end
      iwc_pkg::IWC_STEP: begin
        // the instruction after halt runs first, then vector only if enabled
        if (instr_done_i) begin
          state_nxt = mie ? iwc_pkg::IWC_ENTER : iwc_pkg::IWC_RUN;
        end
      end
      iwc_pkg::IWC_ENTER: begin
        state_nxt   = iwc_pkg::IWC_RUN;
        vec_nxt     = 1'b1;
        push_nxt    = 1'b1;
        push_pc_nxt = pc_i;
        ctrl_nxt[`IWC_BIT_MIE] = 1'b0;
        shadow_nxt[0] = live_status_i & ~`IWC_STATUS_KEEP;
        shadow_nxt[1] = live_w_i;
        shadow_nxt[2] = live_bsr_i;
        shadow_nxt[3] = live_pclh_i;
        shadow_nxt[4] = live_p0l_i;
        shadow_nxt[5] = live_p0h_i;
        shadow_nxt[6] = live_p1l_i;
        shadow_nxt[7] = live_p1h_i;
      end
    endcase
    // return: pop and restore as one pulse, master enable back on
    if (retfie_i && state_r == iwc_pkg::IWC_RUN) begin
      rest_nxt = 1'b1;
      ctrl_nxt[`IWC_BIT_MIE] = 1'b1;
    end
    irq_nxt = |(stat_nxt & mask_nxt);
    rdata_nxt = 8'h00;
    if (rd_i) begin
      unique case (loc)
        `IWC_LOC_CTRL: rdata_nxt = ctrl_r;
        `IWC_LOC_EDGE: rdata_nxt = edge_r;
        `IWC_LOC_PRF3: rdata_nxt = prf3_r;
        `IWC_LOC_MASK: rdata_nxt = mask_r;
        `IWC_LOC_STAT: rdata_nxt = stat_r;
        default: begin
          for (int i = 0; i < 8; i++) begin
            if (sh_hit(1'b1, 3'(i))) begin
              rdata_nxt = shadow_r[i];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        shadow_r[i] <= `IWC_RST_BYTE;
      end
      ctrl_r    <= `IWC_RST_BYTE;
      edge_r    <= `IWC_RST_EDGE;
      prf3_r    <= `IWC_RST_BYTE;
      mask_r    <= `IWC_RST_BYTE;
      stat_r    <= `IWC_RST_BYTE;
      rdata_r   <= `IWC_RST_BYTE;
      pin_d_r   <= 1'b0;
      vec_r     <= 1'b0;
      push_r    <= 1'b0;
      rest_r    <= 1'b0;
      irq_r     <= 1'b0;
      clk_run_r <= 1'b1;
      push_pc_r <= 13'h0000;
      state_r   <= iwc_pkg::IWC_RUN;
    end else begin
      shadow_r  <= shadow_nxt;
      ctrl_r    <= ctrl_nxt;
      edge_r    <= edge_nxt;
      prf3_r    <= prf3_nxt;
      mask_r    <= mask_nxt;
      stat_r    <= stat_nxt;
      rdata_r   <= rdata_nxt;
      pin_d_r   <= pin_d_nxt;
      vec_r     <= vec_nxt;
      push_r    <= push_nxt;
      rest_r    <= rest_nxt;
      irq_r     <= irq_nxt;
      clk_run_r <= clk_run_nxt;
      push_pc_r <= push_pc_nxt;
      state_r   <= state_nxt;
    end
  end

  always_comb begin
    rdata_o          = rdata_r;
    clk_run_o        = clk_run_r;
    vector_o         = vec_r;
    push_o           = push_r;
    push_pc_o        = push_pc_r;
    restore_o        = rest_r;
    restore_status_o = shadow_r[0];
    restore_w_o      = shadow_r[1];
    restore_bsr_o    = shadow_r[2];
    restore_pclh_o   = shadow_r[3];
    restore_p0l_o    = shadow_r[4];
    restore_p0h_o    = shadow_r[5];
    restore_p1l_o    = shadow_r[6];
    restore_p1h_o    = shadow_r[7];
    irq_o            = irq_r;
  end

endmodule

// File: test/iwc_asserts.sv
// iwc_asserts: port-level checks of the wake and context save block, bound below.
// assumes one clock domain and pc_i held steady around each entry.
`timescale 1ns/1ps
module iwc_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        rd_i,
  input wire logic        retfie_i,
  input wire logic        halt_i,
  input wire logic [12:0] pc_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        clk_run_o,
  input wire logic        vector_o,
  input wire logic        push_o,
  input wire logic [12:0] push_pc_o,
  input wire logic        restore_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_wake; $rose(clk_run_o); endsequence
  sequence s_hold; !vector_o [*2]; endsequence
  rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not idle");
  push_vec_a: assert property (push_o == vector_o)
    else $error("push and vector apart");
  push_pc_a: assert property (push_o |-> push_pc_o == $past(pc_i))
    else $error("wrong pushed pc");
  vec_once_a: assert property (vector_o |=> !vector_o)
    else $error("vector longer than a pulse");
  vec_run_a: assert property (vector_o |-> clk_run_o)
    else $error("vector while halted");
  wake_step_a: assert property (s_wake |-> s_hold)
    else $error("vector before the step after halt");
  halt_stop_a: assert property (halt_i |=> !clk_run_o)
    else $error("clock kept running in halt");
  ret_pop_a: assert property (retfie_i |=> restore_o)
    else $error("no restore after return");
endmodule
bind iwc_core iwc_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .rd_i(rd_i), .retfie_i(retfie_i),
  .halt_i(halt_i), .pc_i(pc_i), .rdata_o(rdata_o), .clk_run_o(clk_run_o), .vector_o(vector_o),
  .push_o(push_o), .push_pc_o(push_pc_o), .restore_o(restore_o));

// File: test/iwc_cpu_model.sv
// iwc_cpu_model: processor core beside the block, holding the live registers.
// assumes restore_i is a one-cycle pulse with the shadows valid beside it.
`timescale 1ns/1ps
module iwc_cpu_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        clk_run_i,
  input  wire logic        vector_i,
  input  wire logic        restore_i,
  input  wire logic [63:0] shadow_i,
  output logic      [63:0] live_o,
  output logic             instr_done_o
);
  logic       run_q;
  logic [1:0] step_q;
  assign instr_done_o = step_q[1];
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      live_o <= 64'hA15B030405060708;
      run_q  <= 1'b1;
      step_q <= 2'b00;
    end else begin
      run_q  <= clk_run_i;
      // the instruction after halt retires a little after the clock restarts
      step_q <= {step_q[0], clk_run_i & ~run_q};
      // handler scribbles on the accumulator so a missing restore shows
      if (vector_i) live_o[63:56] <= 8'hEE;
      if (restore_i) live_o <= shadow_i;
    end
  end
endmodule

// File: test/iwc_core_tb.sv
// iwc_core_tb: register, pin edge, entry, restore and halt scenarios.
// assumes the core model of iwc_cpu_model.sv.
`timescale 1ns/1ps
module iwc_core_tb;
  logic        clk_i, rst_i, wr_i, rd_i, pin, cl, done, run, vec, push, rest, irq, hit;
  logic [2:0]  ev;
  logic [11:0] addr_i;
  logic [7:0]  wdata_i, rdata_o;
  logic [12:0] pc, ppc;
  logic [63:0] lv, sh;
  int          err_total, samples_checked, cyc;
  iwc_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .ext_pin_i(pin), .capture3_event_i(ev[0]),
    .cap3_clockless_i(cl), .halt_i(ev[2]), .instr_done_i(done), .retfie_i(ev[1]), .pc_i(pc),
    .live_w_i(lv[63:56]), .live_status_i(lv[55:48]), .live_bsr_i(lv[47:40]),
    .live_pclh_i(lv[39:32]), .live_p0l_i(lv[31:24]), .live_p0h_i(lv[23:16]),
    .live_p1l_i(lv[15:8]), .live_p1h_i(lv[7:0]), .clk_run_o(run), .vector_o(vec),
    .push_o(push), .push_pc_o(ppc), .restore_o(rest), .restore_w_o(sh[63:56]),
    .restore_status_o(sh[55:48]), .restore_bsr_o(sh[47:40]), .restore_pclh_o(sh[39:32]),
    .restore_p0l_o(sh[31:24]), .restore_p0h_o(sh[23:16]), .restore_p1l_o(sh[15:8]),
    .restore_p1h_o(sh[7:0]), .irq_o(irq));
  iwc_cpu_model i_cpu (.clk_i(clk_i), .rst_i(rst_i), .clk_run_i(run), .vector_i(vec),
    .restore_i(rest), .shadow_i(sh), .live_o(lv), .instr_done_o(done));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // wide enough for the two restored bytes compared together
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
    @(posedge clk_i);
  endtask
  task automatic fire(input logic [2:0] e);
    ev <= e;
    @(posedge clk_i);
    ev <= 3'b000;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic edge_to(input logic v);
    pin <= v;
    repeat (5) @(posedge clk_i);
  endtask
  task automatic watch(input int n, input logic exp);
    hit = 1'b0;
    repeat (n) @(negedge clk_i) if (vec === 1'b1) hit = 1'b1;
    chk(hit, exp);
    @(posedge clk_i);
  endtask
  task automatic ck_irq(input logic exp);
    @(negedge clk_i) chk(irq, exp);
    @(posedge clk_i);
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    {rst_i, wr_i, rd_i, pin, cl, ev, addr_i, wdata_i} <= {1'b1, 27'h0000000};
    pc <= 13'h0ABC;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(12'h00B, 8'h00);
    rd(12'h00C, 8'h01);
    rd(12'h00D, 8'h00);
    rd(12'h010, 8'h00);
    rd(12'h065, 8'h00);
    edge_to(1'b1);
    rd(12'h00B, 8'h02);
    wr(12'h00B, 8'h00);
    edge_to(1'b0);
    rd(12'h00B, 8'h00);
    wr(12'h00C, 8'h00);
    edge_to(1'b1);
    rd(12'h00B, 8'h00);
    wr(12'h00E, 8'h01);
    edge_to(1'b0);
    rd(12'h00B, 8'h02);
    ck_irq(1'b1);
    wr(12'h00E, 8'h00);
    ck_irq(1'b0);
    wr(12'h00E, 8'h01);
    wr(12'h00F, 8'h01);
    ck_irq(1'b0);
    wr(12'h00B, 8'h80);
    edge_to(1'b1);
    pin <= 1'b0;
    watch(10, 1'b0);
    wr(12'h00B, 8'h90);
    edge_to(1'b1);
    pin <= 1'b0;
    watch(10, 1'b1);
    chk(ppc, 13'h0ABC);
    rd(12'hFE5, 8'hA1);
    rd(12'hFE4, 8'h43);
    rd(12'hFE6, 8'h03);
    wr(12'hFE5, 8'h3C);
    wr(12'h00B, 8'h10);
    fire(3'b010);
    chk(lv[63:48], 16'h3C43);
    wr(12'h00E, 8'h02);
    fire(3'b100);
    chk(run, 1'b0);
    fire(3'b001);
    chk(run, 1'b0);
    cl <= 1'b1;
    watch(12, 1'b1);
    // pin edge bit is still set from the redirect test, beside capture and wake
    rd(12'h00F, 8'h07);
    rd(12'h00D, 8'h10);
    wr(12'h00D, 8'h00);
    wr(12'h00F, 8'h06);
    fire(3'b010);
    wr(12'h00B, 8'h10);
    fire(3'b100);
    ev <= 3'b001;
    @(posedge clk_i);
    ev <= 3'b000;
    watch(12, 1'b0);
    chk(run, 1'b1);
    tally_and_finish();
  end
endmodule
